// ### hdlc_nrm_pkg.sv
// Constants and types shared by the secondary-station link control
package hdlc_nrm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RXCTL = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Field positions
  localparam int CTRL_ONLINE_BIT = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_SUP_BIT = 1;
  localparam int CMD_FUNC_LSB = 2;
  localparam int CMD_FINAL_BIT = 4;
  localparam int STS_CRC_BIT = 2;
  localparam int STS_REWIND_BIT = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Control field layout, bit 0 sent first
  // ----------------------------------------------------------------
  localparam int PF_BIT = 4;
  localparam int NS_LSB = 1;
  localparam int NR_LSB = 5;
  localparam logic [1:0] S_TYPE = 2'b01;
  localparam logic [7:0] PF_MASK = 8'h10;
  localparam logic [7:0] U_SNRM = 8'h83;
  localparam logic [7:0] U_UA = 8'h63;
  localparam logic [2:0] SEQ_ZERO = 3'h0;
  localparam logic [2:0] SEQ_STEP = 3'h1;
  localparam logic [2:0] RX_MIN_LAST = 3'h3;
  localparam logic [2:0] RX_CNT_SAT = 3'h4;

  // Supervisory function codes
  typedef enum logic [1:0] {
    SF_RR = 2'b00,
    SF_REJ = 2'b01,
    SF_RNR = 2'b10,
    SF_SREJ = 2'b11
  } sfunc_type;

  // ----------------------------------------------------------------
  // Frame check, bit-reversed form of x^16+x^12+x^5+1
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;

  // Transmit sequencer
  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_CTRL = 3'b001,
    T_INFO = 3'b010,
    T_FCS1 = 3'b011,
    T_FCS2 = 3'b100
  } tx_state_type;

endpackage

// ### hdlc_nrm_link_control.sv
// Secondary-station data-link control for an unbalanced normal response link
//
// Summary of operation
// - I-frame: bit0 zero, then send number
// - Send number counts up modulo eight
// - Bit four is poll in, final out
// - Poll received grants turn; answer with final
// - Primary polls only on its last frame
// - Bits 7:5 carry next expected number
// - Supervisory frame marked by bits 1,0
// - Bits 3:2 pick RR, REJ, RNR, SREJ
// - Unnumbered frame has both low bits set
// - Check covers address, control, information only
// - Check polynomial x16+x12+x5+1
// - Append check; receiver flags any mismatch
// - Bad check: discard, no acknowledge, no advance
// - SNRM while online answered by UA final
// - SNRM clears send and receive numbers
// - Final bit on last frame ends turn
// - Lagging acknowledge rewinds send number for resend
// - Transmit only after poll grants turn
// - Flags added and stripped by outside framer
// - Control field is eight bits wide
`timescale 1ns/1ns
module hdlc_nrm_link_control (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Received frame bytes, flags and stuffing already removed
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  // Received byte copy and frame verdict
  output logic rx_byte_valid_out,
  output logic [7:0] rx_byte_out,
  output logic rx_frame_ok_out,
  output logic rx_frame_bad_out,
  // Information bytes to send
  input wire logic tx_info_valid_in,
  input wire logic [7:0] tx_info_data_in,
  input wire logic tx_info_last_in,
  output logic tx_info_ready_out,
  // Transmitted frame bytes towards the framer
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One byte into the check register, first bit is bit 0
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ hdlc_nrm_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == hdlc_nrm_pkg::OFS_CTRL) || (a == hdlc_nrm_pkg::OFS_CMD) ||
           (a == hdlc_nrm_pkg::OFS_STATUS) || (a == hdlc_nrm_pkg::OFS_RXCTL);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic online, link_up, turn, crc_err, rewind_flag, ua_pending;
  logic [7:0] my_addr, rx_ctrl, rx_ctrl_last, aw_addr;
  logic [2:0] vs, vr, rx_cnt;
  logic [15:0] rx_crc, tx_crc;
  logic rx_addr_ok;
  logic cmd_pending, cmd_sup, cmd_final;
  logic [1:0] cmd_func;
  logic cur_ua, cur_sup, cur_final;
  logic [1:0] cur_func;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  hdlc_nrm_pkg::tx_state_type state;

  // ----------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------
  // Verdict is taken on the last byte, so the check never needs a spare byte
  wire [15:0] rx_crc_next = crc_byte(rx_crc, rx_data_in);
  wire rx_end = rx_valid_in && rx_last_in;
  wire rx_good = rx_end && (rx_crc_next == hdlc_nrm_pkg::CRC_RESIDUE) &&
                 (rx_cnt >= hdlc_nrm_pkg::RX_MIN_LAST);
  wire rx_mine = rx_good && rx_addr_ok && online;
  wire is_i = (rx_ctrl[0] == 1'b0);
  wire is_s = (rx_ctrl[1:0] == hdlc_nrm_pkg::S_TYPE);
  wire is_snrm = ((rx_ctrl & ~hdlc_nrm_pkg::PF_MASK) == hdlc_nrm_pkg::U_SNRM);
  wire [2:0] rx_ns = rx_ctrl[hdlc_nrm_pkg::NS_LSB +: 3];
  wire [2:0] rx_nr = rx_ctrl[hdlc_nrm_pkg::NR_LSB +: 3];
  wire rx_poll = rx_mine && rx_ctrl[hdlc_nrm_pkg::PF_BIT];
  wire acc_snrm = rx_mine && is_snrm;
  wire acc_i = rx_mine && link_up && is_i && (rx_ns == vr);
  wire ack_seen = rx_mine && link_up && (is_i || is_s);
  wire rewind = ack_seen && (rx_nr != vs);

  // ----------------------------------------------------------------
  // Transmit decode
  // ----------------------------------------------------------------
  wire load = !tx_valid_out || tx_ready_in;
  wire start_ua = ua_pending && turn;
  wire start_cmd = cmd_pending && turn && link_up;
  wire [7:0] ctrl_byte = cur_ua ? (hdlc_nrm_pkg::U_UA | hdlc_nrm_pkg::PF_MASK) :
                         cur_sup ? {vr, cur_final, cur_func, hdlc_nrm_pkg::S_TYPE} :
                         {vr, cur_final, vs, 1'b0};
  wire info_take = (state == hdlc_nrm_pkg::T_INFO) && load && tx_info_valid_in;
  assign tx_info_ready_out = (state == hdlc_nrm_pkg::T_INFO) && load;
  wire tx_busy = cmd_pending || (state != hdlc_nrm_pkg::T_IDLE);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire wr_fire = aw_held && w_held && !s_axi_bvalid_out;
  wire wr_ctrl = wr_fire && (aw_addr == hdlc_nrm_pkg::OFS_CTRL);
  wire wr_cmd = wr_fire && (aw_addr == hdlc_nrm_pkg::OFS_CMD) && w_strb[0];
  wire wr_sts = wr_fire && (aw_addr == hdlc_nrm_pkg::OFS_STATUS) && w_strb[0];
  wire clr_crc = wr_sts && w_data[hdlc_nrm_pkg::STS_CRC_BIT];
  wire clr_rew = wr_sts && w_data[hdlc_nrm_pkg::STS_REWIND_BIT];
  wire rd_take = s_axi_arvalid_in && !s_axi_rvalid_out;
  wire [31:0] status_word = {16'h0, 1'b0, vr, 1'b0, vs, 3'h0,
                             link_up, rewind_flag, crc_err, tx_busy, turn};
  wire [31:0] ctrl_word = {16'h0, my_addr, 7'h0, online};
  wire [31:0] rd_word = (s_axi_araddr_in == hdlc_nrm_pkg::OFS_CTRL) ? ctrl_word :
                        (s_axi_araddr_in == hdlc_nrm_pkg::OFS_STATUS) ? status_word :
                        (s_axi_araddr_in == hdlc_nrm_pkg::OFS_RXCTL) ? {24'h0, rx_ctrl_last} :
                        32'h0;
  assign s_axi_awready_out = !aw_held;
  assign s_axi_wready_out = !w_held;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  // ----------------------------------------------------------------
  // AXI write and read channels
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= hdlc_nrm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= is_mapped(aw_addr) ? hdlc_nrm_pkg::RESP_OKAY :
                                                hdlc_nrm_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= hdlc_nrm_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_word;
      s_axi_rresp_out <= is_mapped(s_axi_araddr_in) ? hdlc_nrm_pkg::RESP_OKAY :
                                                      hdlc_nrm_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration, command and sticky status
  // ----------------------------------------------------------------
  // Set beats clear so a verdict in the clearing cycle survives
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      online <= hdlc_nrm_pkg::CTRL_RESET[hdlc_nrm_pkg::CTRL_ONLINE_BIT];
      my_addr <= hdlc_nrm_pkg::ADDR_RESET;
      crc_err <= 1'b0;
      rewind_flag <= 1'b0;
      cmd_pending <= 1'b0;
      cmd_sup <= 1'b0;
      cmd_func <= hdlc_nrm_pkg::SF_RR;
      cmd_final <= 1'b0;
    end else begin
      if (wr_ctrl && w_strb[0]) online <= w_data[hdlc_nrm_pkg::CTRL_ONLINE_BIT];
      if (wr_ctrl && w_strb[1]) my_addr <= w_data[hdlc_nrm_pkg::CTRL_ADDR_LSB +: 8];
      crc_err <= (crc_err && !clr_crc) || (rx_end && !rx_good);
      rewind_flag <= (rewind_flag && !clr_rew) || rewind;
      // A command written while one is pending is dropped
      if (wr_cmd && w_data[hdlc_nrm_pkg::CMD_GO_BIT] && !tx_busy) begin
        cmd_pending <= 1'b1;
        cmd_sup <= w_data[hdlc_nrm_pkg::CMD_SUP_BIT];
        cmd_func <= w_data[hdlc_nrm_pkg::CMD_FUNC_LSB +: 2];
        cmd_final <= w_data[hdlc_nrm_pkg::CMD_FINAL_BIT];
      end else if (state == hdlc_nrm_pkg::T_IDLE && load && !start_ua && start_cmd) begin
        cmd_pending <= 1'b0;
      end
      if (!online) cmd_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive path: check register, field capture, verdict
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rx_crc <= hdlc_nrm_pkg::CRC_PRESET;
      rx_cnt <= 3'h0;
      rx_addr_ok <= 1'b0;
      rx_ctrl <= 8'h00;
      rx_ctrl_last <= 8'h00;
      rx_byte_valid_out <= 1'b0;
      rx_byte_out <= 8'h00;
      rx_frame_ok_out <= 1'b0;
      rx_frame_bad_out <= 1'b0;
    end else begin
      rx_byte_valid_out <= rx_valid_in;
      rx_frame_ok_out <= rx_mine;
      rx_frame_bad_out <= rx_end && !rx_good;
      if (rx_valid_in) begin
        rx_byte_out <= rx_data_in;
        rx_crc <= rx_last_in ? hdlc_nrm_pkg::CRC_PRESET : rx_crc_next;
        rx_cnt <= rx_last_in ? 3'h0 :
                  (rx_cnt == hdlc_nrm_pkg::RX_CNT_SAT) ? rx_cnt : rx_cnt + 3'h1;
        if (rx_cnt == 3'h0) rx_addr_ok <= (rx_data_in == my_addr);
        if (rx_cnt == 3'h1) rx_ctrl <= rx_data_in;
      end
      if (rx_mine) rx_ctrl_last <= rx_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Link variables and media access
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      vs <= hdlc_nrm_pkg::SEQ_ZERO;
      vr <= hdlc_nrm_pkg::SEQ_ZERO;
      link_up <= 1'b0;
      ua_pending <= 1'b0;
      turn <= 1'b0;
    end else begin
      if (state == hdlc_nrm_pkg::T_CTRL && load && !cur_ua && !cur_sup) begin
        vs <= vs + hdlc_nrm_pkg::SEQ_STEP;
      end
      if (acc_i) vr <= vr + hdlc_nrm_pkg::SEQ_STEP;
      if (rewind) vs <= rx_nr;
      if (acc_snrm) begin
        vs <= hdlc_nrm_pkg::SEQ_ZERO;
        vr <= hdlc_nrm_pkg::SEQ_ZERO;
        link_up <= 1'b1;
        ua_pending <= 1'b1;
      end else if (state == hdlc_nrm_pkg::T_IDLE && load && start_ua) begin
        ua_pending <= 1'b0;
      end
      // Turn passes back on the last byte of a final frame
      if (state == hdlc_nrm_pkg::T_FCS2 && load && cur_final) turn <= 1'b0;
      if (rx_poll) turn <= 1'b1;
      if (!online) begin
        link_up <= 1'b0;
        ua_pending <= 1'b0;
        turn <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer: address, control, information, check
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state <= hdlc_nrm_pkg::T_IDLE;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_last_out <= 1'b0;
      tx_crc <= hdlc_nrm_pkg::CRC_PRESET;
      cur_ua <= 1'b0;
      cur_sup <= 1'b0;
      cur_final <= 1'b0;
      cur_func <= hdlc_nrm_pkg::SF_RR;
    end else if (load) begin
      tx_last_out <= 1'b0;
      case (state)
        hdlc_nrm_pkg::T_IDLE: begin
          tx_valid_out <= start_ua || start_cmd;
          if (start_ua || start_cmd) begin
            tx_data_out <= my_addr;
            tx_crc <= crc_byte(hdlc_nrm_pkg::CRC_PRESET, my_addr);
            cur_ua <= start_ua;
            cur_sup <= start_ua ? 1'b0 : cmd_sup;
            cur_func <= cmd_func;
            cur_final <= start_ua ? 1'b1 : cmd_final;
            state <= hdlc_nrm_pkg::T_CTRL;
          end
        end
        hdlc_nrm_pkg::T_CTRL: begin
          tx_data_out <= ctrl_byte;
          tx_crc <= crc_byte(tx_crc, ctrl_byte);
          state <= (cur_ua || cur_sup) ? hdlc_nrm_pkg::T_FCS1 : hdlc_nrm_pkg::T_INFO;
        end
        hdlc_nrm_pkg::T_INFO: begin
          tx_valid_out <= tx_info_valid_in;
          if (info_take) begin
            tx_data_out <= tx_info_data_in;
            tx_crc <= crc_byte(tx_crc, tx_info_data_in);
            if (tx_info_last_in) state <= hdlc_nrm_pkg::T_FCS1;
          end
        end
        hdlc_nrm_pkg::T_FCS1: begin
          tx_valid_out <= 1'b1;
          tx_data_out <= ~tx_crc[7:0];
          state <= hdlc_nrm_pkg::T_FCS2;
        end
        hdlc_nrm_pkg::T_FCS2: begin
          tx_data_out <= ~tx_crc[15:8];
          tx_last_out <= 1'b1;
          state <= hdlc_nrm_pkg::T_IDLE;
        end
        default: begin
          tx_valid_out <= 1'b0;
          state <= hdlc_nrm_pkg::T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  a_tx_needs_turn: assert property (
    (state == hdlc_nrm_pkg::T_CTRL && $rose(tx_valid_out)) |-> $past(turn))
    else $error("frame started without a granted turn");
  a_iframe_ctrl: assert property (
    (state == hdlc_nrm_pkg::T_CTRL && load && !cur_ua && !cur_sup) |=>
    (tx_data_out[0] == 1'b0) && (tx_data_out[3:1] == $past(vs)) && (vs == $past(vs) + 3'h1))
    else $error("information control field wrong");
  a_sframe_ctrl: assert property (
    (state == hdlc_nrm_pkg::T_CTRL && load && cur_sup) |=>
    (tx_data_out[1:0] == 2'b01) && (tx_data_out[3:2] == $past(cur_func)) && vs == $past(vs))
    else $error("supervisory control field wrong");
  a_ua_final: assert property (
    (state == hdlc_nrm_pkg::T_CTRL && load && cur_ua) |=> (tx_data_out == 8'h73))
    else $error("acknowledge not sent with final bit");
  a_snrm_reset: assert property (
    acc_snrm |=> (vs == 3'h0) && (vr == 3'h0) && ua_pending && link_up)
    else $error("link set-up did not clear numbers");
  a_vr_advance: assert property (
    acc_i |=> (vr == $past(vr) + 3'h1))
    else $error("receive number did not advance");
  a_bad_hold: assert property (
    (rx_end && !rx_good) |=> (vr == $past(vr)) && rx_frame_bad_out && !rx_frame_ok_out && crc_err)
    else $error("bad frame was not discarded");
  a_final_turn: assert property (
    (state == hdlc_nrm_pkg::T_FCS2 && load && cur_final && !rx_poll) |=> !turn && tx_last_out)
    else $error("final frame kept the turn");
  a_rewind_seq: assert property (
    (rewind && !acc_snrm) |=> (vs == $past(rx_nr)) && rewind_flag)
    else $error("send number not rewound");

endmodule

// ### primary_model.sv
// Primary station model: sends frames to the secondary and paces its transmit
`timescale 1ns/1ns
module primary_model (
  // Clock
  input wire logic clk_in,
  // Frame bytes towards the secondary
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out,
  // Transmit pacing
  input wire logic slow_in,
  output logic tx_ready_out
);
  // ----------------------------------------------------------------
  // Frame check and framing
  // ----------------------------------------------------------------
  // Reflected check, preset to ones, covering only the bytes handed in
  function automatic logic [15:0] fcs(input logic [7:0] b[$]);
    logic [15:0] c;
    c = hdlc_nrm_pkg::CRC_PRESET;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ hdlc_nrm_pkg::CRC_POLY_REFL : c >> 1;
    end
    return ~c;
  endfunction

  // Bytes go back to back, low check byte first; bad flips one check bit
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [15:0] f;
    f = fcs(b) ^ {15'h0000, bad};
    b.push_back(f[7:0]);
    b.push_back(f[15:8]);
    foreach (b[i]) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= b[i];
      rx_last_out <= (i == b.size() - 1);
      @(posedge clk_in);
    end
    // Released lines show the inverse, so a stale byte is never mistaken
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~b[b.size() - 1];
    repeat (3) @(posedge clk_in);
  endtask

  // Ready toggles when slow, to stall the transmitter every other cycle
  initial begin
    {rx_valid_out, rx_last_out, rx_data_out, tx_ready_out} = '0;
  end
  always @(posedge clk_in) tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
endmodule

// ### testbench.sv
// Self-checking bench for the secondary-station link control
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] ADR = 8'h5a;
  logic clk, rstn, awv, wv, bready, arv, rready, infv, infl, slow, rxv, rxl;
  logic [7:0] awaddr, araddr, infd, rxd;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awr, wr_r, bv, arr, rv, txv, txl, txrdy, infr, ok, bad, rbv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] txd, rbd, exp_rb[$];
  logic [8:0] exp_tx[$], info_q[$];
  logic [33:0] exp_rd[$];
  logic [1:0] exp_b[$], exp_rx[$];
  logic [7:0] q[$];
  int n_fail, n_compared, seed, i;

  hdlc_nrm_link_control DUT (.ref_clk_in(clk), .rstn_in(rstn),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_r), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .rx_valid_in(rxv), .rx_data_in(rxd),
    .rx_last_in(rxl), .rx_byte_valid_out(rbv), .rx_byte_out(rbd), .rx_frame_ok_out(ok),
    .rx_frame_bad_out(bad), .tx_info_valid_in(infv), .tx_info_data_in(infd),
    .tx_info_last_in(infl), .tx_info_ready_out(infr), .tx_valid_out(txv),
    .tx_data_out(txd), .tx_last_out(txl), .tx_ready_in(txrdy));
  primary_model pm (.clk_in(clk), .rx_valid_out(rxv), .rx_data_out(rxd),
    .rx_last_out(rxl), .slow_in(slow), .tx_ready_out(txrdy));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Notes never consumed count as missing results
  task automatic wrap_up();
    n_fail += exp_tx.size() + exp_rx.size() + exp_rd.size() + exp_b.size() + exp_rb.size();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 400) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ha, hw;
    exp_b.push_back(r);
    {ha, hw} = 2'b00;
    awaddr <= a;
    wdata <= d;
    {awv, wv} <= 2'b11;
    for (n = 0; n < 400 && !(ha && hw); n++) begin
      @(posedge clk);
      {ha, hw} = {ha | awr, hw | wr_r};
      {awv, wv} <= {~ha, ~hw};
    end
    tmo(n);
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!bv && n < 400);
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_rd.push_back(e);
    araddr <= a;
    {arv, rready} <= 2'b11;
    n = 0;
    do begin
      @(posedge clk);
      arv <= arv & ~arr;
      n++;
    end while (!rv && n < 400);
    rready <= 1'b0;
    tmo(n);
    // One idle edge so a following read never reassigns arvalid in this step
    @(posedge clk);
  endtask
  // Expected transmit: bytes handed in, then the complemented check, low first
  task automatic expect_frame(input logic [7:0] b[$]);
    logic [15:0] f;
    f = pm.fcs(b);
    b.push_back(f[7:0]);
    b.push_back(f[15:8]);
    foreach (b[i]) exp_tx.push_back({i == b.size() - 1, b[i]});
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 400 && exp_tx.size() > 0; n++) @(posedge clk);
    tmo(n);
    repeat (2) @(posedge clk);
  endtask

  // Clock, info source and result watcher
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (!infv || infr) begin
    infv <= info_q.size() > 0;
    {infl, infd} <= info_q.size() > 0 ? info_q.pop_front() : {1'b0, ~infd};
  end
  always @(posedge clk) if (rstn) begin
    if (txv && txrdy) chk("tx byte", exp_tx.size() ? exp_tx.pop_front() : 'x, {txl, txd});
    if (bv && bready) chk("bresp", exp_b.size() ? exp_b.pop_front() : 'x, bresp);
    if (rv && rready) chk("read", exp_rd.size() ? exp_rd.pop_front() : 'x, {rresp, rdata});
    if (ok || bad) chk("verdict", exp_rx.size() ? exp_rx.pop_front() : 'x, {ok, bad});
    if (rbv) chk("rx byte", exp_rb.size() ? exp_rb.pop_front() : 'x, rbd);
    if (rxv) exp_rb.push_back(rxd);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, awv, wv, bready, arv, rready, infv, infl, slow, awaddr, araddr, infd, wdata} = '0;
    {n_fail, n_compared} = '0;
    wstrb = 4'hf;
    seed = 32'hb4abe4d0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h00, {2'b00, 32'h0});
    rd(8'h10, {2'b10, 32'h0});
    wr(8'h20, 32'h1, 2'b10);
    // Set-up while offline draws no answer; the retry after going online does
    pm.send('{ADR, 8'h93}, 1'b0);
    wr(8'h00, {16'h0000, ADR, 8'h01}, 2'b00);
    exp_rx.push_back(2'b10);
    expect_frame('{ADR, 8'h73});
    pm.send('{ADR, 8'h93}, 1'b0);
    drain();
    rd(8'h08, {2'b00, 32'h10});
    // Low strobe only: online kept, station address must survive
    wstrb <= 4'h1;
    wr(8'h00, 32'h1, 2'b00);
    wstrb <= 4'hf;
    rd(8'h00, {2'b00, 16'h0, ADR, 8'h01});
    // Corrupted check is discarded and leaves the receive number alone
    exp_rx.push_back(2'b01);
    pm.send('{ADR, 8'h10}, 1'b1);
    rd(8'h08, {2'b00, 32'h14});
    wr(8'h08, 32'h4, 2'b00);
    // Polled I-frame grants the turn; reply I-frame with random info, stalled
    exp_rx.push_back(2'b10);
    pm.send('{ADR, 8'h10}, 1'b0);
    rd(8'h08, {2'b00, 32'h1011});
    slow <= 1'b1;
    q = '{ADR, 8'h30};
    for (i = 0; i < 3; i++) begin
      q.push_back(8'($random(seed)));
      info_q.push_back({i == 2, q[i + 2]});
    end
    expect_frame(q);
    wr(8'h04, 32'h11, 2'b00);
    drain();
    rd(8'h08, {2'b00, 32'h1110});
    // Every supervisory function, each after its own poll
    for (i = 0; i < 4; i++) begin
      exp_rx.push_back(2'b10);
      pm.send('{ADR, 8'h31}, 1'b0);
      expect_frame('{ADR, 8'h31 | 8'(i << 2)});
      wr(8'h04, 32'h13 | (i << 2), 2'b00);
      drain();
    end
    // Poll bit clear: data acknowledged, no turn given
    exp_rx.push_back(2'b10);
    pm.send('{ADR, 8'h22}, 1'b0);
    rd(8'h08, {2'b00, 32'h2110});
    // Lagging acknowledge rewinds the send number
    exp_rx.push_back(2'b10);
    pm.send('{ADR, 8'h11}, 1'b0);
    rd(8'h08, {2'b00, 32'h2019});
    rd(8'h0c, {2'b00, 32'h11});
    // Another station's frame draws no verdict
    pm.send('{ADR ^ 8'hff, 8'h10}, 1'b0);
    rd(8'h04, {2'b00, 32'h0});
    wrap_up();
  end
endmodule
